// [hw/hpf_pkg.sv]
// Package: register map, fields, reset values and carrier types
package hpf_pkg;
  localparam int NPIN = 6;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PULSE = 8'h04;
  localparam logic [7:0] OFS_REGTO = 8'h08;
  localparam logic [7:0] OFS_HOPS = 8'h0C;
  localparam logic [7:0] OFS_GCFG = 8'h10;
  localparam logic [7:0] OFS_GSLP = 8'h14;
  localparam logic [7:0] OFS_GIN = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_LINK = 8'h24;
  localparam int B_ROLE = 0;
  localparam int B_ACT_ALT = 2;
  localparam int B_DCD_ALT = 3;
  localparam int B_FC_ALT = 4;
  localparam int B_SLEEP = 5;
  localparam int B_DIR = 0;
  localparam int B_OUT = 8;
  localparam int B_PU = 16;
  localparam int B_WAKE = 24;
  localparam int ST_ACT = 0;
  localparam int ST_UP = 1;
  localparam int ST_DOWN = 2;
  localparam int ST_WAKE = 3;
  localparam int NST = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] PULSE_RST = 16'h1000;
  localparam logic [31:0] REGTO_RST = 32'h0BEBC200;
  localparam logic [7:0] HOPS_RST = 8'h32;
  localparam logic [31:0] GCFG_RST = 32'h00000000;
  localparam logic [31:0] GSLP_RST = 32'h00000000;
  typedef enum logic [1:0] {
    ROLE_BASE = 2'b00,
    ROLE_REMOTE = 2'b01,
    ROLE_ROUTER = 2'b10
  } hpf_role_t;
  typedef enum logic [0:0] {
    LINK_DOWN = 1'b0,
    LINK_UP = 1'b1
  } hpf_link_t;
  typedef struct packed {
    logic rx_valid;
    logic tx_pkt;
    logic rx_up;
    logic tx_down;
    logic hop_sync;
    logic hop_tick;
    logic beacon;
  } hpf_evt_t;
  typedef struct packed {
    logic [NPIN-1:0] o;
    logic [NPIN-1:0] oe_n;
    logic [NPIN-1:0] pu_en;
  } hpf_gpo_t;
endpackage

// [hw/hpf_top.sv]
// Host pin status, general pins and flow control with APB registers
`timescale 1ns/1ps
module hpf_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire hpf_pkg::hpf_evt_t evt,
  input wire logic diag_serial_out_int,
  output logic diag_serial_in,
  output logic packet_activity_out,
  input wire logic link_pin_i,
  output logic link_detect_n,
  output logic link_pin_oe_n,
  input wire logic [hpf_pkg::NPIN-1:0] gp_i,
  output hpf_pkg::hpf_gpo_t gp,
  output logic wake_out,
  input wire logic uart_tx_int,
  output logic module_serial_out,
  input wire logic module_serial_in,
  output logic rx_serial,
  input wire logic rx_can_accept,
  output logic tx_allowed
);
  import hpf_pkg::*;

  logic [5:0] ctrl_q;
  logic [15:0] pulse_q;
  logic [31:0] regto_q;
  logic [7:0] hops_q;
  logic [31:0] gcfg_q;
  logic [31:0] gslp_q;
  logic [NST-1:0] stat_q;
  logic [NST-1:0] mask_q;
  logic [15:0] act_cnt_q;
  logic [31:0] to_cnt_q;
  logic [7:0] miss_q;
  hpf_link_t link_q;
  hpf_link_t link_d;
  logic [NPIN-1:0] gp_prev_q;
  logic [NPIN-1:0] gp_low_edge;
  logic act_evt;
  logic link_up_evt;
  logic link_dn_evt;
  logic wake_evt;
  logic wr_en;
  logic [NST-1:0] st_set;
  logic [NST-1:0] st_clr;
  hpf_role_t role;
  logic [NPIN-1:0] cur_dir;
  logic [NPIN-1:0] cur_out;
  logic [NPIN-1:0] cur_pu;
  logic sleeping;
  logic fc_on;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_CTRL) | hit(a, OFS_PULSE) | hit(a, OFS_REGTO) |
             hit(a, OFS_HOPS) | hit(a, OFS_GCFG) | hit(a, OFS_GSLP) |
             hit(a, OFS_GIN) | hit(a, OFS_STAT) | hit(a, OFS_MASK) |
             hit(a, OFS_LINK);
  endfunction

  assign role = hpf_role_t'(ctrl_q[B_ROLE +: 2]);
  assign sleeping = ctrl_q[B_SLEEP];
  assign fc_on = ctrl_q[B_FC_ALT];
  assign wr_en = psel & penable & pready & pwrite;

  // Qualifying activity event per role
  always_comb begin
    case (role)
      ROLE_BASE: act_evt = evt.rx_valid;
      ROLE_REMOTE: act_evt = evt.tx_pkt;
      ROLE_ROUTER: act_evt = evt.rx_up | evt.tx_down;
      default: act_evt = 1'b0;
    endcase
  end

  // APB access timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite) begin
        if (hit(paddr, OFS_CTRL)) begin
          prdata <= {26'h0, ctrl_q};
        end else if (hit(paddr, OFS_PULSE)) begin
          prdata <= {16'h0000, pulse_q};
        end else if (hit(paddr, OFS_REGTO)) begin
          prdata <= regto_q;
        end else if (hit(paddr, OFS_HOPS)) begin
          prdata <= {24'h000000, hops_q};
        end else if (hit(paddr, OFS_GCFG)) begin
          prdata <= gcfg_q;
        end else if (hit(paddr, OFS_GSLP)) begin
          prdata <= gslp_q;
        end else if (hit(paddr, OFS_GIN)) begin
          prdata <= {26'h0, gp_i};
        end else if (hit(paddr, OFS_STAT)) begin
          prdata <= {28'h0000000, stat_q};
        end else if (hit(paddr, OFS_MASK)) begin
          prdata <= {28'h0000000, mask_q};
        end else if (hit(paddr, OFS_LINK)) begin
          prdata <= {23'h0, link_q, miss_q};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      pulse_q <= PULSE_RST;
      regto_q <= REGTO_RST;
      hops_q <= HOPS_RST;
      gcfg_q <= GCFG_RST;
      gslp_q <= GSLP_RST;
      mask_q <= '0;
    end else if (wr_en) begin
      if (hit(paddr, OFS_CTRL)) begin
        ctrl_q <= pwdata[5:0];
      end else if (hit(paddr, OFS_PULSE)) begin
        pulse_q <= pwdata[15:0];
      end else if (hit(paddr, OFS_REGTO)) begin
        regto_q <= pwdata;
      end else if (hit(paddr, OFS_HOPS)) begin
        hops_q <= pwdata[7:0];
      end else if (hit(paddr, OFS_GCFG)) begin
        gcfg_q <= pwdata;
      end else if (hit(paddr, OFS_GSLP)) begin
        gslp_q <= pwdata;
      end else if (hit(paddr, OFS_MASK)) begin
        mask_q <= pwdata[NST-1:0];
      end
    end
  end

  // Sticky status, set wins over write-one clear
  assign st_clr = (wr_en && hit(paddr, OFS_STAT)) ? pwdata[NST-1:0] : '0;
  always_comb begin
    st_set = '0;
    st_set[ST_ACT] = act_evt;
    st_set[ST_UP] = link_up_evt;
    st_set[ST_DOWN] = link_dn_evt;
    st_set[ST_WAKE] = wake_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      irq <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~st_clr) | st_set;
      irq <= |(((stat_q & ~st_clr) | st_set) & mask_q);
    end
  end

  // Activity pulse timer, restarted by each event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_cnt_q <= '0;
    end else if (act_evt) begin
      act_cnt_q <= pulse_q;
    end else if (act_cnt_q != 16'h0000) begin
      act_cnt_q <= act_cnt_q - 16'h0001;
    end
  end

  // Link state machine
  always_comb begin
    link_d = link_q;
    case (link_q)
      LINK_DOWN: begin
        if (role == ROLE_BASE) begin
          if (evt.rx_valid) link_d = LINK_UP;
        end else if (evt.hop_sync) begin
          link_d = LINK_UP;
        end
      end
      LINK_UP: begin
        if (role == ROLE_BASE) begin
          if (!evt.rx_valid && to_cnt_q <= 32'h00000001) link_d = LINK_DOWN;
        end else if (evt.hop_tick && !evt.beacon && !evt.hop_sync &&
                     (miss_q + 8'h01) >= hops_q) begin
          link_d = LINK_DOWN;
        end
      end
      default: link_d = LINK_DOWN;
    endcase
  end

  assign link_up_evt = (link_q == LINK_DOWN) && (link_d == LINK_UP);
  assign link_dn_evt = (link_q == LINK_UP) && (link_d == LINK_DOWN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= LINK_DOWN;
    end else begin
      link_q <= link_d;
    end
  end

  // Registration timeout and beacon miss counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_cnt_q <= '0;
    end else if (evt.rx_valid) begin
      to_cnt_q <= regto_q;
    end else if (to_cnt_q != 32'h00000000) begin
      to_cnt_q <= to_cnt_q - 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q <= '0;
    end else if (evt.beacon || evt.hop_sync || link_d == LINK_DOWN) begin
      miss_q <= '0;
    end else if (evt.hop_tick) begin
      miss_q <= miss_q + 8'h01;
    end
  end

  // Status and diagnostic pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      packet_activity_out <= 1'b0;
      link_detect_n <= 1'b1;
      link_pin_oe_n <= 1'b0;
      diag_serial_in <= 1'b1;
    end else begin
      if (ctrl_q[B_ACT_ALT]) begin
        packet_activity_out <= diag_serial_out_int;
      end else begin
        packet_activity_out <= act_evt | (act_cnt_q > 16'h0001);
      end
      link_detect_n <= ~(link_d == LINK_UP);
      link_pin_oe_n <= ctrl_q[B_DCD_ALT];
      diag_serial_in <= ctrl_q[B_DCD_ALT] ? link_pin_i : 1'b1;
    end
  end

  // General pin settings, awake or asleep
  assign cur_dir = sleeping ? gslp_q[B_DIR +: NPIN] : gcfg_q[B_DIR +: NPIN];
  assign cur_out = sleeping ? gslp_q[B_OUT +: NPIN] : gcfg_q[B_OUT +: NPIN];
  assign cur_pu = sleeping ? gslp_q[B_PU +: NPIN] : gcfg_q[B_PU +: NPIN];

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic fc_pin;
      assign fc_pin = fc_on && (gi == 4 || gi == 5);
      assign gp_low_edge[gi] = gp_prev_q[gi] & ~gp_i[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gp.o[gi] <= GCFG_RST[B_OUT + gi];
          gp.oe_n[gi] <= ~GCFG_RST[B_DIR + gi];
          gp.pu_en[gi] <= GCFG_RST[B_PU + gi];
        end else if (fc_pin && gi == 4) begin
          gp.o[gi] <= ~rx_can_accept;
          gp.oe_n[gi] <= 1'b0;
          gp.pu_en[gi] <= 1'b0;
        end else if (fc_pin) begin
          gp.o[gi] <= 1'b1;
          gp.oe_n[gi] <= 1'b1;
          gp.pu_en[gi] <= 1'b0;
        end else begin
          gp.o[gi] <= cur_out[gi];
          gp.oe_n[gi] <= ~cur_dir[gi];
          gp.pu_en[gi] <= ~cur_dir[gi] & cur_pu[gi];
        end
      end
    end
  endgenerate

  // Wake on falling edge of an enabled input while asleep
  assign wake_evt = sleeping & |(gp_low_edge & ~gslp_q[B_DIR +: NPIN] &
                    gcfg_q[B_WAKE +: NPIN]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_prev_q <= '1;
      wake_out <= 1'b0;
    end else begin
      gp_prev_q <= gp_i;
      wake_out <= wake_evt;
    end
  end

  // Primary serial path and host flow control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_serial_out <= 1'b1;
      rx_serial <= 1'b1;
      tx_allowed <= 1'b1;
    end else begin
      module_serial_out <= uart_tx_int;
      rx_serial <= module_serial_in;
      tx_allowed <= ~fc_on | ~gp_i[5];
    end
  end

  AST_BASE_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    role == ROLE_BASE && !ctrl_q[B_ACT_ALT] && evt.rx_valid && !wr_en
    |=> packet_activity_out) else $error("base activity missing");
  AST_REMOTE_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    role == ROLE_REMOTE && !ctrl_q[B_ACT_ALT] && evt.tx_pkt && !wr_en
    |=> packet_activity_out) else $error("remote activity missing");
  AST_ROUTER_ACT: assert property (@(posedge pclk) disable iff (!presetn)
    role == ROLE_ROUTER && !ctrl_q[B_ACT_ALT] && (evt.rx_up || evt.tx_down) && !wr_en
    |=> packet_activity_out) else $error("router activity missing");
  AST_DIAG_SERIAL_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[B_ACT_ALT] && !wr_en |=> packet_activity_out == $past(diag_serial_out_int))
    else $error("diag out not routed");
  AST_BASE_LINK: assert property (@(posedge pclk) disable iff (!presetn)
    role == ROLE_BASE && evt.rx_valid && !wr_en |=> !link_detect_n)
    else $error("base link not asserted");
  AST_HOP_LOSS: assert property (@(posedge pclk) disable iff (!presetn)
    role != ROLE_BASE && link_q == LINK_UP && evt.hop_tick && !evt.beacon &&
    !evt.hop_sync && miss_q + 8'h01 == hops_q && !wr_en |=> link_detect_n)
    else $error("link kept after lost beacons");
  AST_DIAG_SERIAL_IN: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[B_DCD_ALT] && !wr_en |=> link_pin_oe_n ##0
    diag_serial_in == $past(link_pin_i)) else $error("diag in not routed");
  AST_FC_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    fc_on && !wr_en |=> !gp.oe_n[4] && gp.o[4] == !$past(rx_can_accept))
    else $error("host-may-send wrong");
  AST_FC_IN: assert property (@(posedge pclk) disable iff (!presetn)
    fc_on && gp_i[5] && !wr_en |=> !tx_allowed ##0 gp.oe_n[5])
    else $error("send not stopped");
  AST_PULSE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
    act_evt && pulse_q == 16'h0003 && !wr_en ##1 !act_evt [*3]
    |=> !packet_activity_out || ctrl_q[B_ACT_ALT])
    else $error("pulse length wrong");
  AST_SLEEP_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && !fc_on && !wr_en |=> gp.o == $past(gslp_q[B_OUT +: NPIN]))
    else $error("sleep level not applied");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    |(stat_q & mask_q) && st_clr == '0 |=> irq) else $error("irq missing");
endmodule

// [tb/hpf_host.sv]
// Host controller model on the serial and flow-control pins
`timescale 1ns/1ps
module hpf_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_may_send_n,
  input wire logic stall,
  output logic module_may_send_n,
  output logic module_serial_in
);
  logic [3:0] pat_q;
  // Host holds the line high to stop the device
  assign module_may_send_n = stall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_q <= 4'h0;
    end else if (!host_may_send_n) begin
      pat_q <= pat_q + 4'h1;
    end
  end
  // Line idles high while sending is not allowed
  assign module_serial_in = host_may_send_n ? 1'b1 : pat_q[0];
endmodule

// [tb/test_hpf_top.sv]
// Testbench for host pin status, general pins and flow control
`timescale 1ns/1ps
module test_hpf_top;
  import hpf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic errv, s, seen;
  hpf_evt_t evt;
  hpf_gpo_t gp;
  logic diag_serial_out_int, diag_serial_in, packet_activity_out, link_pin_i, link_detect_n;
  logic link_pin_oe_n, wake_out, uart_tx_int, module_serial_out, msi, rx_serial;
  logic rx_can_accept, tx_allowed, stall, mms_n;
  logic [4:0] gp_ext;
  logic [NPIN-1:0] gp_i;
  int err_total, n_tests;
  assign gp_i = (gp.o & ~gp.oe_n) | ({mms_n, gp_ext} & gp.oe_n);
  hpf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .evt(evt), .diag_serial_out_int(diag_serial_out_int),
    .diag_serial_in(diag_serial_in), .packet_activity_out(packet_activity_out),
    .link_pin_i(link_pin_i), .link_detect_n(link_detect_n), .link_pin_oe_n(link_pin_oe_n),
    .gp_i(gp_i), .gp(gp), .wake_out(wake_out), .uart_tx_int(uart_tx_int),
    .module_serial_out(module_serial_out), .module_serial_in(msi), .rx_serial(rx_serial),
    .rx_can_accept(rx_can_accept), .tx_allowed(tx_allowed));
  hpf_host host (.pclk(pclk), .presetn(presetn), .host_may_send_n(gp.o[4]), .stall(stall),
    .module_may_send_n(mms_n), .module_serial_in(msi));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic ev(input int k);
    @(posedge pclk);
    evt <= hpf_evt_t'(7'(1 << k));
    @(posedge pclk);
    evt <= '0;
    #1;
  endtask
  task automatic pchk();
    for (int i = 0; i < 4; i++) begin
      chk(packet_activity_out, i < 3);
      wt(1);
    end
  endtask
  task automatic alt(input logic v);
    @(posedge pclk);
    diag_serial_out_int <= v;
    link_pin_i <= v;
    wt(2);
    chk(packet_activity_out, v);
    chk(diag_serial_in, v);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, evt} = '0;
    {diag_serial_out_int, link_pin_i, uart_tx_int, rx_can_accept, stall} = 5'h1F;
    gp_ext = 5'h10;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_PULSE, {16'h0, PULSE_RST});
    rchk(OFS_REGTO, REGTO_RST);
    rchk(OFS_HOPS, {24'h0, HOPS_RST});
    xfer(1'b0, 8'hFC, 32'h0);
    chk(errv, 1'b1);
    chk(link_detect_n, 1'b1);
    $display("test reset done");
    wr(OFS_PULSE, 32'h3);
    wr(OFS_REGTO, 32'h14);
    wr(OFS_MASK, 32'h4);
    ev(6);
    chk(link_detect_n, 1'b0);
    pchk();
    ev(6);
    ev(6);
    pchk();
    ev(5);
    chk(packet_activity_out, 1'b0);
    wt(10);
    chk(link_detect_n, 1'b0);
    wt(15);
    chk(link_detect_n, 1'b1);
    chk(irq, 1'b1);
    wr(OFS_STAT, 32'hF);
    rchk(OFS_STAT, 32'h0);
    chk(irq, 1'b0);
    $display("test base done");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_HOPS, 32'h3);
    ev(6);
    chk(packet_activity_out, 1'b0);
    ev(5);
    pchk();
    ev(2);
    chk(link_detect_n, 1'b0);
    ev(1);
    ev(1);
    ev(0);
    ev(1);
    ev(1);
    chk(link_detect_n, 1'b0);
    rchk(OFS_LINK, 32'h102);
    ev(1);
    wt(2);
    chk(link_detect_n, 1'b1);
    wr(OFS_CTRL, 32'h2);
    ev(4);
    pchk();
    ev(3);
    pchk();
    $display("test roles done");
    wr(OFS_CTRL, 32'hC);
    alt(1'b0);
    alt(1'b1);
    chk(link_pin_oe_n, 1'b1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_GCFG, 32'h2030050F);
    wt(2);
    chk(gp.oe_n, 6'h30);
    chk(gp.o[3:0], 4'h5);
    chk(gp.pu_en, 6'h30);
    rchk(OFS_GIN, 32'h35);
    wr(OFS_GSLP, 32'h00020101);
    wr(OFS_CTRL, 32'h20);
    wt(2);
    chk(gp.oe_n, 6'h3E);
    chk(gp.o[0], 1'b1);
    chk(gp.pu_en, 6'h02);
    @(posedge pclk);
    stall <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      wt(1);
      if (wake_out === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    xfer(1'b0, OFS_STAT, 32'h0);
    chk(rdv[3], 1'b1);
    $display("test pins done");
    wr(OFS_CTRL, 32'h10);
    @(posedge pclk);
    rx_can_accept <= 1'b0;
    wt(2);
    chk(gp.o[4], 1'b1);
    chk(gp.oe_n[4], 1'b0);
    @(posedge pclk);
    rx_can_accept <= 1'b1;
    wt(2);
    chk(gp.o[4], 1'b0);
    s = msi;
    wt(1);
    chk(rx_serial, s);
    @(posedge pclk);
    stall <= 1'b1;
    uart_tx_int <= 1'b0;
    wt(2);
    chk(tx_allowed, 1'b0);
    chk(module_serial_out, 1'b0);
    @(posedge pclk);
    stall <= 1'b0;
    wt(2);
    chk(tx_allowed, 1'b1);
    $display("test flow control done");
    final_report();
  end
endmodule
